// >>> include/slpcg_pkg.sv
package slpcg_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_EXT_BIT = 8;
  localparam int STAT_WDT_BIT = 9;
  localparam logic [7:0] GATE_WMASK = 8'hEF;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam int GATE_CONV = 0;
  localparam int GATE_T2 = 6;
  localparam logic [2:0] BOD_DISABLED = 3'h7;

  // ----------------------------------------------------------------
  // Sleep state codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NRED = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h6;

  // ----------------------------------------------------------------
  // Timing, in clock cycles, and the counter width in bits
  // ----------------------------------------------------------------
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int STARTUP_CYCLES_DEF = 16384;
  localparam int CNT_W = 16;

  typedef enum logic [3:0] {
    FSM_RUN = 4'b0001,
    FSM_SLEEP = 4'b0010,
    FSM_START = 4'b0100,
    FSM_HALT = 4'b1000
  } slpcg_fsm_t;

  typedef struct packed {
    logic ext_level_a;
    logic ext_level_b;
    logic ext_edge_a;
    logic ext_edge_b;
    logic pin_change;
    logic addr_match;
    logic timer_two_overflow;
    logic timer_two_compare;
    logic store_ready;
    logic converter_done;
    logic watchdog;
    logic other_io;
  } slpcg_wake_t;

  typedef struct packed {
    logic core_clock_domain;
    logic program_memory_clock;
    logic peripheral_io_clock;
    logic converter_clock;
    logic async_timer_clock;
    logic main_source_en;
    logic timer_osc_en;
  } slpcg_clk_t;

  typedef struct packed {
    logic comparator_off;
    logic comparator_mux_ok;
    logic input_buffers_off;
    logic brownout_en;
    logic watchdog_en;
    logic vref_en;
    logic extended_conversion;
  } slpcg_analog_t;

endpackage

// >>> src/slpcg_ctrl.sv
`timescale 1ns/10ps
module slpcg_ctrl #(
  parameter int STARTUP_CYCLES = slpcg_pkg::STARTUP_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core
  input wire logic sleep_instr,
  input wire logic global_irq_enable,
  output logic core_resume,
  // Wake sources and timer two
  input wire slpcg_pkg::slpcg_wake_t wake_in,
  input wire logic [1:0] timer_two_irq_mask,
  input wire logic timer_two_running,
  input wire logic timer_two_async_select,
  // Analog and fuses
  input wire logic converter_enable,
  input wire logic conversion_start,
  input wire logic comparator_enable,
  input wire logic comparator_uses_ref,
  input wire logic watchdog_enable,
  input wire logic debug_enable_fuse,
  input wire logic [2:0] brownout_level_fuse,
  input wire logic crystal_clock_option,
  // Clock and power controls
  output slpcg_pkg::slpcg_clk_t clk_out,
  output logic [7:0] periph_clock_en,
  output logic [7:0] periph_io_blocked,
  output slpcg_pkg::slpcg_analog_t analog_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    slpcg_pkg::slpcg_fsm_t fsm;
    logic [2:0] mode;
    logic [slpcg_pkg::CNT_W-1:0] cnt;
    logic sleep_arm;
    logic [2:0] sleep_state_select;
    logic [7:0] peripheral_clock_gate;
    logic conv_en_seen;
    logic resume;
    slpcg_pkg::slpcg_clk_t clk;
    logic [7:0] pclk_en;
    logic [7:0] io_blk;
    slpcg_pkg::slpcg_analog_t ana;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } slpcg_state_t;

  localparam logic [slpcg_pkg::CNT_W-1:0] HALT_LOAD = slpcg_pkg::CNT_W'(slpcg_pkg::WAKE_HALT_CYCLES - 1);
  localparam logic [slpcg_pkg::CNT_W-1:0] STBY_LOAD = slpcg_pkg::CNT_W'(slpcg_pkg::STANDBY_WAKE_CYCLES - 1);
  localparam logic [slpcg_pkg::CNT_W-1:0] START_LOAD = slpcg_pkg::CNT_W'(STARTUP_CYCLES - 1);

  slpcg_state_t st;
  slpcg_state_t next_st;

  // ----------------------------------------------------------------
  // Clock domains for the present state
  // ----------------------------------------------------------------
  logic asleep;
  logic m_idle;
  logic m_nred;
  logic m_psave;
  logic m_stby;
  logic io_on;
  logic adc_on;
  logic t2_sync_on;
  logic [7:0] eff_gate;
  logic [7:0] periph_on;

  assign asleep = (st.fsm == slpcg_pkg::FSM_SLEEP);
  assign m_idle = asleep && (st.mode == slpcg_pkg::MODE_IDLE);
  assign m_nred = asleep && (st.mode == slpcg_pkg::MODE_NRED);
  assign m_psave = asleep && (st.mode == slpcg_pkg::MODE_PSAVE);
  assign m_stby = asleep && (st.mode == slpcg_pkg::MODE_STBY);
  assign io_on = !asleep || m_idle;
  assign adc_on = !asleep || m_idle || m_nred;
  // Only timer two may see the synchronous clock in power-save
  assign t2_sync_on = m_psave && timer_two_running && !timer_two_async_select;

  // Timer two in asynchronous mode ignores its gating bit
  always_comb begin
    eff_gate = st.peripheral_clock_gate;
    eff_gate[slpcg_pkg::GATE_T2] = st.peripheral_clock_gate[slpcg_pkg::GATE_T2] && !timer_two_async_select;
  end

  // Deeper states stop the domain, so the gate only matters in active and idle, plus noise reduction for the converter and power-save for timer two
  for (genvar i = 0; i < 8; i++) begin : g_periph
    if (i == slpcg_pkg::GATE_CONV) begin : g_conv
      assign periph_on[i] = adc_on && !eff_gate[i];
    end else if (i == slpcg_pkg::GATE_T2) begin : g_t2
      // A gated synchronous timer stays stopped in power-save as well
      assign periph_on[i] = (io_on || t2_sync_on) && !eff_gate[i];
    end else begin : g_io
      assign periph_on[i] = io_on && !eff_gate[i];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic t2_wake;
    logic ext_level;
    logic ext_edge;
    logic wake;
    logic sel_ok;
    logic comp_auto_off;
    logic wr;
    logic rd;
    next_st = st;
    t2_wake = global_irq_enable &&
              ((wake_in.timer_two_overflow && timer_two_irq_mask[0]) ||
               (wake_in.timer_two_compare && timer_two_irq_mask[1]));
    ext_level = wake_in.ext_level_a || wake_in.ext_level_b || wake_in.pin_change;
    ext_edge = wake_in.ext_edge_a || wake_in.ext_edge_b;
    wake = 1'b0;
    sel_ok = 1'b0;
    comp_auto_off = asleep && !m_idle && !m_nred;
    wr = psel && penable && st.rdy && pwrite;
    rd = psel && !penable;

    // Accepted wake sources per sleep state; edges wake only from idle
    case (st.mode)
      slpcg_pkg::MODE_IDLE: begin
        wake = ext_level || ext_edge || wake_in.addr_match || t2_wake || wake_in.store_ready ||
               wake_in.converter_done || wake_in.watchdog || wake_in.other_io;
      end
      slpcg_pkg::MODE_NRED: begin
        wake = ext_level || wake_in.addr_match || t2_wake || wake_in.store_ready ||
               wake_in.converter_done || wake_in.watchdog;
      end
      slpcg_pkg::MODE_PSAVE: begin
        wake = ext_level || wake_in.addr_match || t2_wake || wake_in.watchdog;
      end
      default: begin
        wake = ext_level || wake_in.addr_match || wake_in.watchdog;
      end
    endcase

    case (st.sleep_state_select)
      slpcg_pkg::MODE_IDLE, slpcg_pkg::MODE_NRED, slpcg_pkg::MODE_PDOWN, slpcg_pkg::MODE_PSAVE: begin
        sel_ok = 1'b1;
      end
      slpcg_pkg::MODE_STBY: begin
        sel_ok = crystal_clock_option;
      end
      default: begin
        sel_ok = 1'b0;
      end
    endcase

    // Sleep sequencer
    next_st.resume = 1'b0;
    case (st.fsm)
      slpcg_pkg::FSM_RUN: begin
        if (sleep_instr && st.sleep_arm && sel_ok) begin
          next_st.fsm = slpcg_pkg::FSM_SLEEP;
          next_st.mode = st.sleep_state_select;
        end
      end
      slpcg_pkg::FSM_SLEEP: begin
        if (wake) begin
          if (st.mode == slpcg_pkg::MODE_STBY) begin
            next_st.fsm = slpcg_pkg::FSM_HALT;
            next_st.cnt = STBY_LOAD;
          end else if (st.mode == slpcg_pkg::MODE_PDOWN || st.mode == slpcg_pkg::MODE_PSAVE) begin
            next_st.fsm = slpcg_pkg::FSM_START;
            next_st.cnt = START_LOAD;
          end else begin
            next_st.fsm = slpcg_pkg::FSM_HALT;
            next_st.cnt = HALT_LOAD;
          end
        end
      end
      slpcg_pkg::FSM_START: begin
        if (st.cnt == '0) begin
          next_st.fsm = slpcg_pkg::FSM_HALT;
          next_st.cnt = HALT_LOAD;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      slpcg_pkg::FSM_HALT: begin
        if (st.cnt == '0) begin
          next_st.fsm = slpcg_pkg::FSM_RUN;
          next_st.resume = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: begin
        next_st.fsm = slpcg_pkg::FSM_RUN;
      end
    endcase

    // Clock and oscillator enables
    next_st.clk.core_clock_domain = (st.fsm == slpcg_pkg::FSM_RUN);
    next_st.clk.program_memory_clock = (st.fsm == slpcg_pkg::FSM_RUN);
    next_st.clk.peripheral_io_clock = io_on;
    next_st.clk.converter_clock = adc_on;
    next_st.clk.async_timer_clock = !asleep || m_idle || m_nred || m_psave;
    // A debug session must not lose its clock in any sleep state
    next_st.clk.main_source_en = debug_enable_fuse || !asleep || m_idle || m_nred ||
                                 m_stby || t2_sync_on;
    next_st.clk.timer_osc_en = timer_two_async_select && (!asleep || m_idle || m_nred || m_psave);
    next_st.pclk_en = periph_on;
    next_st.io_blk = eff_gate;

    // Analog housekeeping
    next_st.ana.comparator_off = comp_auto_off || !comparator_enable;
    next_st.ana.comparator_mux_ok = !st.peripheral_clock_gate[slpcg_pkg::GATE_CONV];
    next_st.ana.input_buffers_off = !io_on && !adc_on;
    next_st.ana.brownout_en = (brownout_level_fuse != slpcg_pkg::BOD_DISABLED);
    next_st.ana.watchdog_en = watchdog_enable;
    // A comparator set up on the reference keeps it on whatever the sleep state
    next_st.ana.vref_en = next_st.ana.brownout_en || converter_enable ||
                          (comparator_enable && comparator_uses_ref);
    // Converter enable is never forced off by sleep; a re-enable demands a long conversion
    next_st.conv_en_seen = converter_enable;
    if (converter_enable && !st.conv_en_seen) begin
      next_st.ana.extended_conversion = 1'b1;
    end else if (conversion_start) begin
      next_st.ana.extended_conversion = 1'b0;
    end

    // APB slave: ready in the first access cycle
    next_st.rdy = rd;
    next_st.err = 1'b0;
    if (rd) begin
      next_st.rdata = 32'h0000_0000;
      case (paddr)
        slpcg_pkg::ADDR_CTRL: begin
          next_st.rdata[slpcg_pkg::CTRL_ARM_BIT] = st.sleep_arm;
          next_st.rdata[slpcg_pkg::CTRL_SEL_LSB +: 3] = st.sleep_state_select;
        end
        slpcg_pkg::ADDR_GATE: begin
          next_st.rdata[7:0] = st.peripheral_clock_gate;
        end
        slpcg_pkg::ADDR_STATUS: begin
          next_st.rdata[3:0] = st.fsm;
          next_st.rdata[slpcg_pkg::STAT_MODE_LSB +: 3] = st.mode;
          next_st.rdata[slpcg_pkg::STAT_EXT_BIT] = st.ana.extended_conversion;
          next_st.rdata[slpcg_pkg::STAT_WDT_BIT] = st.ana.watchdog_en;
        end
        default: begin
          next_st.err = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        slpcg_pkg::ADDR_CTRL: begin
          next_st.sleep_arm = pwdata[slpcg_pkg::CTRL_ARM_BIT];
          next_st.sleep_state_select = pwdata[slpcg_pkg::CTRL_SEL_LSB +: 3];
        end
        slpcg_pkg::ADDR_GATE: begin
          next_st.peripheral_clock_gate = pwdata[7:0] & slpcg_pkg::GATE_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= slpcg_pkg::FSM_RUN;
      st.sleep_state_select <= slpcg_pkg::SEL_RESET;
      st.peripheral_clock_gate <= slpcg_pkg::GATE_RESET;
      st.clk <= '1;
      st.clk.timer_osc_en <= 1'b0;
      st.pclk_en <= 8'hFF;
      st.ana.comparator_mux_ok <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign core_resume = st.resume;
  assign clk_out = st.clk;
  assign periph_clock_en = st.pclk_en;
  assign periph_io_blocked = st.io_blk;
  assign analog_out = st.ana;

endmodule

// >>> bench/slpcg_chk.sv
`timescale 1ns/10ps
module slpcg_chk (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Core and static inputs
  input wire logic core_resume,
  input wire logic timer_two_async_select,
  input wire logic converter_enable,
  input wire logic watchdog_enable,
  input wire logic debug_enable_fuse,
  input wire logic [2:0] brownout_level_fuse,
  // Controls
  input wire slpcg_pkg::slpcg_clk_t clk_out,
  input wire logic [7:0] periph_clock_en,
  input wire logic [7:0] periph_io_blocked,
  input wire slpcg_pkg::slpcg_analog_t analog_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  apb_ready_a:
    assert property (psel && !penable && clk_en |=> pready ##1 !pready) else $error("pready not one cycle");
  gate_bit4_a:
    assert property (periph_io_blocked[4] == 1'b0) else $error("reserved gate bit set");
  gate_exclusive_a:
    assert property ((periph_io_blocked & periph_clock_en) == 8'h00) else $error("blocked peripheral clocked");
  t2_async_a:
    assert property (timer_two_async_select && clk_en |=> !periph_io_blocked[6]) else $error("async timer gated");
  wdt_kept_a:
    assert property (presetn && clk_en |=> analog_out.watchdog_en == $past(watchdog_enable))
      else $error("watchdog lost");
  bod_kept_a:
    assert property (presetn && clk_en
      |=> analog_out.brownout_en == ($past(brownout_level_fuse) != slpcg_pkg::BOD_DISABLED))
      else $error("brownout enable wrong");
  debug_main_a:
    assert property (presetn && debug_enable_fuse && clk_en |=> clk_out.main_source_en)
      else $error("main source off");
  vref_need_a:
    assert property ((converter_enable || brownout_level_fuse != slpcg_pkg::BOD_DISABLED) && presetn && clk_en
      |=> analog_out.vref_en) else $error("reference off while needed");
  resume_pulse_a:
    assert property (core_resume |=> !core_resume && clk_out.core_clock_domain) else $error("resume pulse wrong");
  cpu_flash_a:
    assert property (clk_out.core_clock_domain == clk_out.program_memory_clock) else $error("core clocks split");
  input_buffers_a:
    assert property (analog_out.input_buffers_off == (!clk_out.peripheral_io_clock && !clk_out.converter_clock))
      else $error("input buffers wrong");
  comparator_mux_a:
    assert property (analog_out.comparator_mux_ok == !periph_io_blocked[0]) else $error("mux access wrong");

  cover property (psel && penable && pready);
  cover property (core_resume);
  cover property ($fell(clk_out.core_clock_domain));
endmodule

bind slpcg_ctrl slpcg_chk slpcg_chk_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready),
  .core_resume(core_resume), .timer_two_async_select(timer_two_async_select),
  .converter_enable(converter_enable), .watchdog_enable(watchdog_enable),
  .debug_enable_fuse(debug_enable_fuse), .brownout_level_fuse(brownout_level_fuse),
  .clk_out(clk_out), .periph_clock_en(periph_clock_en), .periph_io_blocked(periph_io_blocked),
  .analog_out(analog_out)
);

// >>> bench/slpcg_core_model.sv
`timescale 1ns/10ps
module slpcg_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic sleep_go,
  input wire slpcg_pkg::slpcg_wake_t wake_req,
  // Block side
  input wire logic core_resume,
  output logic sleep_instr,
  output slpcg_pkg::slpcg_wake_t wake_in
);
  // A taken interrupt drops its request, as the core acknowledges it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      wake_in <= '0;
    end else begin
      sleep_instr <= sleep_go;
      wake_in <= core_resume ? '0 : wake_req;
    end
  end
endmodule

// >>> bench/slpcg_ctrl_bench.sv
`timescale 1ns/10ps
module slpcg_ctrl_bench;
  // Short start-up keeps deep-sleep wakes quick
  localparam int SU = 8;
  // Core model edge, wake sampling edge and the edge that shows the resume pulse
  localparam int HW = slpcg_pkg::WAKE_HALT_CYCLES + 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sleep_go, sleep_instr, core_resume;
  logic clk_en, gie, tt_run, tt_async, comp_en, comp_ref, wdt_en, dbg, xtal, conv_en, conv_start;
  logic [7:0] paddr, pce, pib;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] tt_mask;
  logic [2:0] bod;
  slpcg_pkg::slpcg_wake_t wake_in, wake_req;
  slpcg_pkg::slpcg_clk_t clk_out;
  slpcg_pkg::slpcg_analog_t analog_out;
  int fail_count = 0;
  int num_checks = 0;

  slpcg_ctrl #(.STARTUP_CYCLES(SU)) slpcg_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr(sleep_instr), .global_irq_enable(gie),
    .core_resume(core_resume), .wake_in(wake_in), .timer_two_irq_mask(tt_mask),
    .timer_two_running(tt_run), .timer_two_async_select(tt_async), .converter_enable(conv_en),
    .conversion_start(conv_start), .comparator_enable(comp_en), .comparator_uses_ref(comp_ref),
    .watchdog_enable(wdt_en), .debug_enable_fuse(dbg), .brownout_level_fuse(bod),
    .crystal_clock_option(xtal), .clk_out(clk_out), .periph_clock_en(pce),
    .periph_io_blocked(pib), .analog_out(analog_out)
  );
  slpcg_core_model slpcg_core_model_inst (
    .pclk(pclk), .presetn(presetn), .sleep_go(sleep_go), .wake_req(wake_req),
    .core_resume(core_resume), .sleep_instr(sleep_instr), .wake_in(wake_in)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from driving psel twice in one step
    @(posedge pclk);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic nap(input logic [3:0] c);
    apb(1'b1, slpcg_pkg::ADDR_CTRL, {28'h000_0000, c});
    sleep_go <= 1'b1;
    @(posedge pclk);
    sleep_go <= 1'b0;
    tick(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_gate();
    conv_en <= 1'b0;
    tt_async <= 1'b0;
    apb(1'b1, slpcg_pkg::ADDR_GATE, 32'hFFFF_FFFF);
    apb(1'b0, slpcg_pkg::ADDR_GATE, 32'h0000_0000);
    check("gate readback", rd, {24'h00_0000, slpcg_pkg::GATE_WMASK});
    check("io blocked", pib, 8'hEF);
    check("clock enables", pce, 8'h10);
    tt_async <= 1'b1;
    tick(2);
    check("async timer", pib, 8'hAF);
    // The serial blocks stay unused after ungating, so no re-initialisation is due
    apb(1'b1, slpcg_pkg::ADDR_GATE, 32'h0000_0000);
    tick(1);
    check("ungated", pce, 8'hFF);
    conv_en <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check("unmapped error", err, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
  endtask

  task automatic t_conv();
    check("extended set", analog_out.extended_conversion, 1'b1);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
    tick(2);
    check("extended cleared", analog_out.extended_conversion, 1'b0);
  endtask

  task automatic t_refuse();
    logic [3:0] codes [5] = '{4'h0, 4'h9, 4'hB, 4'hF, 4'hD};
    xtal <= 1'b0;
    foreach (codes[i]) begin
      nap(codes[i]);
      check("refused sleep", clk_out, 7'h7F);
    end
    xtal <= 1'b1;
  endtask

  task automatic t_mode(input logic [2:0] sel, input logic [6:0] ec, input logic [11:0] bad, good,
                        input int lat, input logic deep);
    int n;
    nap({sel, 1'b1});
    check("clocks", clk_out, ec);
    check("comparator off", analog_out.comparator_off, deep);
    check("buffers off", analog_out.input_buffers_off, deep);
    apb(1'b0, slpcg_pkg::ADDR_STATUS, 32'h0000_0000);
    check("status", rd[6:0], {sel, slpcg_pkg::FSM_SLEEP});
    wake_req <= bad;
    tick(4);
    check("ignored wake", clk_out, ec);
    wake_req <= good;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_resume !== 1'b1 && n < 60);
    wake_req <= '0;
    check("wake latency", n, lat);
    if (n >= 60) summarize();
  endtask

  initial begin
    {presetn, psel, penable, pwrite, sleep_go, conv_start, dbg, comp_ref, tt_async} = '0;
    {clk_en, gie, tt_run, comp_en, wdt_en, conv_en, xtal} = '1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tt_mask = 2'b00;
    bod = 3'h7;
    wake_req = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, slpcg_pkg::ADDR_GATE, 32'h0000_0000);
    check("gate reset", rd, {24'h00_0000, slpcg_pkg::GATE_RESET});
    t_gate();
    t_conv();
    t_refuse();
    t_mode(slpcg_pkg::MODE_IDLE, 7'h1F, 12'h000, 12'h001, HW, 1'b0);
    t_mode(slpcg_pkg::MODE_NRED, 7'h0F, 12'h201, 12'h004, HW, 1'b0);
    t_mode(slpcg_pkg::MODE_PDOWN, 7'h00, 12'h208, 12'h800, SU + HW, 1'b1);
    // Timer two keeps running here, so power-save is the sensible choice
    tt_mask <= 2'b10;
    t_mode(slpcg_pkg::MODE_PSAVE, 7'h05, 12'h124, 12'h010, SU + HW, 1'b1);
    t_mode(slpcg_pkg::MODE_STBY, 7'h02, 12'h220, 12'h002, slpcg_pkg::STANDBY_WAKE_CYCLES + 3, 1'b1);
    // Clock enable low must freeze every output
    clk_en <= 1'b0;
    wdt_en <= 1'b0;
    bod <= 3'h4;
    dbg <= 1'b1;
    tick(3);
    check("frozen watchdog", analog_out.watchdog_en, 1'b1);
    check("frozen brownout", analog_out.brownout_en, 1'b0);
    clk_en <= 1'b1;
    tick(3);
    check("watchdog", analog_out.watchdog_en, 1'b0);
    check("brownout", analog_out.brownout_en, 1'b1);
    t_mode(slpcg_pkg::MODE_PDOWN, 7'h02, 12'h000, 12'h800, SU + HW, 1'b1);
    summarize();
  end
endmodule
